// ==== bench/clock_ctrl_assertions.sv ====
`timescale 1ns/1ps
module clock_ctrl_checker
  import clock_ctrl_pkg::*;
#(
  parameter int XTAL_EDGES = 4,
  parameter int SYN_EDGES  = 4
) (
  // Clock and reset
  input wire logic              clock,
  input wire logic              rst,
  // Register port
  input wire reg_req_s          bus_req,
  input wire logic [DATA_W-1:0] rdata_ff,
  input wire logic              bus_hold_ff,
  // Source and mode inputs
  input wire logic              synthesised_clock,
  input wire logic              self_clock_mode,
  input wire logic              debug_mode,
  input wire logic              clocks_off_ready,
  input wire logic              wakeup,
  // Watched outputs
  input wire logic              filter_acq_ff,
  input wire logic              system_clock_ff,
  input wire logic              peripheral_bus_clock_ff,
  input wire logic              osc_derived_clock_ff,
  input wire logic              clock_freeze_ff,
  input wire logic              doze_mode_ff,
  input wire logic              stop_clocks_ff,
  input wire logic              watchdog_run_ff,
  input wire logic              tick_run_ff
);
  // Longest switch window, generous for slow bench sources
  localparam int MAXF = 32 * (XTAL_EDGES + SYN_EDGES);
  logic sd_wr;

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  // Accepted write to the stop and doze register
  assign sd_wr = bus_req.wr && !bus_hold_ff
                 && bus_req.addr == OFS_STOPDOZE;

  chk_stop_hold: assert property (
    sd_wr && bus_req.wdata[BIT_STOP] |=> bus_hold_ff)
    else $error("bus not held after stop write");
  chk_hold_wake: assert property (
    bus_hold_ff && !wakeup |=> bus_hold_ff)
    else $error("bus hold dropped without wakeup");
  chk_stop_clocks: assert property (
    bus_hold_ff && clocks_off_ready && !wakeup |=> stop_clocks_ff)
    else $error("clocks not stopped when ready");
  chk_doze_entry: assert property (
    sd_wr && bus_req.wdata[1:0] == 2'b10 && !wakeup ##1 !wakeup
    |=> doze_mode_ff)
    else $error("doze not entered two cycles after write");
  chk_counter_pair: assert property (
    watchdog_run_ff == tick_run_ff
    && (watchdog_run_ff || $past(debug_mode)))
    else $error("watchdog and tick gates differ");
  chk_freeze_still: assert property (
    clock_freeze_ff && $past(clock_freeze_ff) |-> $stable(system_clock_ff))
    else $error("system clock moved during freeze");
  chk_freeze_bound: assert property (
    $rose(clock_freeze_ff) |-> ##[1:MAXF] !clock_freeze_ff)
    else $error("clock switch took too long");
  chk_periph_half: assert property (
    $rose(system_clock_ff) |-> ##[0:1] $changed(peripheral_bus_clock_ff))
    else $error("peripheral clock missed a system rise");
  chk_self_source: assert property (
    !$past(rst) && $past(self_clock_mode)
    |-> osc_derived_clock_ff == $past(synthesised_clock))
    else $error("self clock source not synthesised");
  chk_track_acq: assert property (
    bus_req.rd && !bus_hold_ff && bus_req.addr == OFS_FLAG
    && filter_acq_ff && $past(filter_acq_ff) && $past(filter_acq_ff, 2)
    |=> !rdata_ff[BIT_TRACK])
    else $error("track flag set in acquisition");
endmodule

bind pll_clock_and_low_power_control clock_ctrl_checker #(
  .XTAL_EDGES(XTAL_EDGES),
  .SYN_EDGES (SYN_EDGES)
) i_clock_ctrl_checker (.*);

// ==== bench/test_pll_clock_and_low_power_control.sv ====
`timescale 1ns/1ps
module test_pll_clock_and_low_power_control
  import clock_ctrl_pkg::*;
  ;
  localparam int XP = 16;
  logic              clock, rst, crystal_clock, synthesised_clock;
  logic              debug_mode, self_clock_mode, clocks_off_ready, wakeup;
  reg_req_s          bus_req;
  logic [DATA_W-1:0] rdata_ff, v;
  logic              bus_hold_ff, synth_enable_ff, filter_acq_ff;
  logic              ref_clock_ff, fb_clock_ff, system_clock_ff;
  logic              peripheral_bus_clock_ff, osc_derived_clock_ff;
  logic              clock_freeze_ff, doze_mode_ff, stop_clocks_ff;
  logic              watchdog_run_ff, tick_run_ff, lock_irq_ff;
  int                n_fail, compares, xc, sc, syn_half, i;
  logic [7:0]        rv [8];

  pll_clock_and_low_power_control i_pll_clock_and_low_power_control (.*);

  // System clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Crystal and synthesiser stand-ins, sampled by the block
  always @(posedge clock) begin
    xc <= (xc == XP / 2 - 1) ? 0 : xc + 1;
    sc <= (sc >= syn_half - 1) ? 0 : sc + 1;
    if (xc == XP / 2 - 1) crystal_clock <= ~crystal_clock;
    if (sc >= syn_half - 1) synthesised_clock <= ~synthesised_clock;
  end

  task conclude;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task cmp(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Output level checked two settled cycles later
  task automatic chk(ref logic g, input logic e);
    repeat (2) @(negedge clock);
    cmp(g, e);
    @(posedge clock);
  endtask

  task wr(input logic [2:0] a, input logic [7:0] d);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clock);
    bus_req <= '0;
    @(posedge clock);
  endtask

  task rd(input logic [2:0] a, output logic [7:0] d);
    bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clock);
    bus_req <= '0;
    @(negedge clock);
    d = rdata_ff;
    @(posedge clock);
  endtask

  task rc(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    cmp(d, e);
  endtask

  // Read the flags until one bit reaches the wanted level
  task poll(input int b, input logic e);
    logic [7:0] d;
    for (int k = 0; k < 300; k++) begin
      rd(OFS_FLAG, d);
      if (d[b] === e) break;
    end
    cmp(d[b], e);
  endtask

  // Cycles between two divider pulses
  task gap(input logic f, input int e);
    int n;
    n = 0;
    do @(negedge clock); while ((f ? fb_clock_ff : ref_clock_ff) !== 1'b1);
    do begin
      @(negedge clock);
      n++;
    end while ((f ? fb_clock_ff : ref_clock_ff) !== 1'b1 && n < 300);
    cmp(n[7:0], e[7:0]);
    @(posedge clock);
  endtask

  // Clock output follows the chosen source one cycle late
  task follow(input logic o, input logic s);
    logic p, sp, q;
    @(negedge clock);
    p = s ? synthesised_clock : crystal_clock;
    {sp, q} = {system_clock_ff, peripheral_bus_clock_ff};
    repeat (12) begin
      @(negedge clock);
      cmp(o ? osc_derived_clock_ff : system_clock_ff, p);
      if (!o) begin
        cmp(peripheral_bus_clock_ff, q ^ (system_clock_ff & ~sp));
      end
      p = s ? synthesised_clock : crystal_clock;
      {sp, q} = {system_clock_ff, peripheral_bus_clock_ff};
    end
    @(posedge clock);
  endtask

  task sw(input logic [7:0] d);
    wr(OFS_SELECT, d);
    chk(clock_freeze_ff, 1'b1);
    for (i = 0; i < 300 && clock_freeze_ff === 1'b1; i++) @(negedge clock);
    cmp(i <= 4 * XP + 8 * syn_half, 1'b1);
    follow(1'b0, d[7]);
  endtask

  // Stimulus
  initial begin
    rst = 1'b1;
    bus_req = '0;
    {crystal_clock, synthesised_clock, debug_mode} = 3'h0;
    {self_clock_mode, clocks_off_ready, wakeup} = 3'h0;
    {xc, sc, n_fail, compares} = {4{32'sd0}};
    syn_half = 4;
    rv = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h30, 8'h00, 8'h00};
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(negedge clock);
    cmp(filter_acq_ff, 1'b1);
    cmp(watchdog_run_ff, 1'b1);
    @(posedge clock);
    for (i = 0; i < 8; i++) rc(i[2:0], rv[i]);
    wr(OFS_MULT, 8'hFF);
    rc(OFS_MULT, 8'h3F);
    wr(OFS_STOPDOZE, 8'hFC);
    rc(OFS_STOPDOZE, 8'h00);
    chk(doze_mode_ff, 1'b0);
    wr(OFS_MULT, 8'h01);
    wr(OFS_REFERENCE_DIVIDE_REGISTER, 8'h01);
    wr(OFS_SYNCTL, 8'h60);
    gap(1'b0, XP * (1 + 1));
    gap(1'b1, 2 * syn_half * 2 * (1 + 1));
    poll(BIT_LOCK, 1'b1);
    poll(BIT_TRACK, 1'b1);
    chk(filter_acq_ff, 1'b0);
    wr(OFS_INT, 8'h10);
    chk(lock_irq_ff, 1'b1);
    wr(OFS_FLAG, 8'h80);
    rc(OFS_FLAG, 8'h0C);
    chk(lock_irq_ff, 1'b0);
    syn_half <= 6;
    poll(BIT_LOCK, 1'b0);
    poll(BIT_TRACK, 1'b0);
    chk(lock_irq_ff, 1'b1);
    chk(filter_acq_ff, 1'b1);
    syn_half <= 4;
    wr(OFS_FLAG, 8'h80);
    poll(BIT_LOCK, 1'b1);
    wr(OFS_SYNCTL, 8'h50);
    rd(OFS_FLAG, v);
    cmp(v[BIT_TRACK], 1'b0);
    chk(filter_acq_ff, 1'b1);
    wr(OFS_SYNCTL, 8'h40);
    rd(OFS_FLAG, v);
    cmp(v[BIT_TRACK], 1'b1);
    chk(filter_acq_ff, 1'b0);
    wr(OFS_SYNCTL, 8'h60);
    poll(BIT_LOCK, 1'b1);
    sw(8'h80);
    wr(OFS_SYNCTL, 8'h20);
    chk(synth_enable_ff, 1'b1);
    sw(8'h00);
    wr(OFS_SYNCTL, 8'h20);
    chk(synth_enable_ff, 1'b0);
    self_clock_mode <= 1'b1;
    repeat (2) @(posedge clock);
    follow(1'b1, 1'b1);
    self_clock_mode <= 1'b0;
    repeat (2) @(posedge clock);
    follow(1'b1, 1'b0);
    debug_mode <= 1'b1;
    chk(watchdog_run_ff, 1'b1);
    wr(OFS_DBGFREEZE, 8'hFF);
    rc(OFS_DBGFREEZE, 8'h40);
    chk(watchdog_run_ff, 1'b0);
    chk(tick_run_ff, 1'b0);
    wr(OFS_DBGFREEZE, 8'h00);
    rc(OFS_DBGFREEZE, 8'h40);
    debug_mode <= 1'b0;
    chk(tick_run_ff, 1'b1);
    wr(OFS_STOPDOZE, 8'h02);
    chk(doze_mode_ff, 1'b1);
    rc(OFS_STOPDOZE, 8'h02);
    wakeup <= 1'b1;
    @(posedge clock);
    wakeup <= 1'b0;
    chk(doze_mode_ff, 1'b0);
    wr(OFS_STOPDOZE, 8'h01);
    chk(bus_hold_ff, 1'b1);
    rd(OFS_DBGFREEZE, v);
    cmp(v, 8'h02);
    chk(stop_clocks_ff, 1'b0);
    clocks_off_ready <= 1'b1;
    chk(stop_clocks_ff, 1'b1);
    wakeup <= 1'b1;
    @(posedge clock);
    wakeup <= 1'b0;
    clocks_off_ready <= 1'b0;
    chk(bus_hold_ff, 1'b0);
    rc(OFS_STOPDOZE, 8'h00);
    conclude;
  end

  // Watchdog for a hung run
  initial begin
    repeat (40000) @(posedge clock);
    n_fail++;
    conclude;
  end
endmodule

// ==== shared/clock_ctrl_pkg.sv ====
package clock_ctrl_pkg;

  // Register bus shape
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_MULT      = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_REFERENCE_DIVIDE_REGISTER    = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_FLAG      = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_INT       = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_SELECT    = 3'h4;
  localparam logic [ADDR_W-1:0] OFS_SYNCTL    = 3'h5;
  localparam logic [ADDR_W-1:0] OFS_STOPDOZE  = 3'h6;
  localparam logic [ADDR_W-1:0] OFS_DBGFREEZE = 3'h7;

  // Field positions
  localparam int MULT_W        = 6;
  localparam int REFERENCE_DIVIDE_FIELD_W       = 4;
  localparam int BIT_LOCKCHG   = 7;
  localparam int BIT_LOCK      = 3;
  localparam int BIT_TRACK     = 2;
  localparam int BIT_LOCK_INTERRUPT_ENABLE    = 4;
  localparam int BIT_SYNSEL    = 7;
  localparam int BIT_SYNON     = 6;
  localparam int BIT_AUTO      = 5;
  localparam int BIT_ACQ       = 4;
  localparam int BIT_DOZE      = 1;
  localparam int BIT_STOP      = 0;
  localparam int BIT_DBGFREEZE = 6;

  // Reset values
  localparam logic [MULT_W-1:0]  MULT_RST  = 6'h00;
  localparam logic [REFERENCE_DIVIDE_FIELD_W-1:0] REFERENCE_DIVIDE_FIELD_RST = 4'h0;
  localparam logic               AUTO_RST  = 1'b1;
  localparam logic               ACQ_RST   = 1'b1;

  // Clock switch: crystal edges then synthesised edges
  localparam logic [2:0] SWITCH_XTAL_EDGES = 3'h4;
  localparam logic [2:0] SWITCH_SYN_EDGES  = 3'h4;

  // Lock detector period measurement
  localparam int PER_W = 16;
  localparam logic [PER_W-1:0] PER_MAX      = 16'hFFFF;
  localparam logic [PER_W-1:0] TOL_LOCK     = 16'h0002;
  localparam logic [PER_W-1:0] TOL_UNLOCK   = 16'h0004;
  localparam logic [PER_W-1:0] TOL_TRACK    = 16'h0004;
  localparam logic [PER_W-1:0] TOL_UNTRACK  = 16'h0008;

  typedef enum logic [1:0] {
    PW_RUN, PW_DOZE, PW_STOP_WAIT, PW_STOPPED
  } power_state_e;

  typedef enum logic [1:0] {
    SW_IDLE, SW_XTAL, SW_SYN
  } switch_state_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_s;

endpackage

// ==== src/pll_clock_and_low_power_control.sv ====
`timescale 1ns/1ps

// Summary of operation
// - With stop bit zero, writing one to doze bit starts doze sequence; zero stays in run.
// - Writing stop bit starts stop sequence; bus held until wake-up from stop.
// - Debug freeze bit writes once; halts watchdog and tick in debug mode.
// - Reference divider divides crystal clock by divide field plus one.
// - Synthesised frequency is 2 x crystal x (mult+1)/(div+1).
// - Feedback divider divides synthesised clock by 2 x (mult+1).
// - Select bit set takes system clock from synthesised clock.
// - Acquisition mode forces track flag to read zero.
// - Nearly correct frequency enters tracking and sets track flag.
// - Automatic mode lets lock detector switch filter mode itself.
// - Automatic track flag read-only, set/cleared by track tolerances.
// - Automatic lock flag read-only, set/cleared by lock tolerances.
// - With lock interrupt enable, each lock flag change requests interrupt.
// - Manual mode: acquisition bit one picks wide filter, zero narrow.
// - System clock is twice peripheral clock; CPU cycle is one period.
// - Self-clock mode replaces crystal-derived clock with synthesised clock.
// - Clearing power-on bit cannot stop synthesiser while it is selected.
// - Select change takes 4 crystal plus 4 synthesised edges, system and peripheral clocks frozen.
module pll_clock_and_low_power_control
  import clock_ctrl_pkg::*;
#(
  parameter int XTAL_EDGES = SWITCH_XTAL_EDGES,
  parameter int SYN_EDGES  = SWITCH_SYN_EDGES
) (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              rst,
  // Register port
  input  wire reg_req_s          bus_req,
  output logic [DATA_W-1:0]      rdata_ff,
  output logic                   bus_hold_ff,
  // Source clocks, sampled
  input  wire logic              crystal_clock,
  input  wire logic              synthesised_clock,
  // Device mode inputs
  input  wire logic              debug_mode,
  input  wire logic              self_clock_mode,
  input  wire logic              clocks_off_ready,
  input  wire logic              wakeup,
  // Synthesiser analog controls
  output logic                   synth_enable_ff,
  output logic                   filter_acq_ff,
  output logic                   ref_clock_ff,
  output logic                   fb_clock_ff,
  // Generated clocks, gates and lock interrupt
  output logic                   system_clock_ff,
  output logic                   peripheral_bus_clock_ff,
  output logic                   osc_derived_clock_ff,
  output logic                   clock_freeze_ff,
  output logic                   doze_mode_ff,
  output logic                   stop_clocks_ff,
  output logic                   watchdog_run_ff,
  output logic                   tick_run_ff,
  output logic                   lock_irq_ff
);

  // Distance between two measured periods
  function automatic logic [PER_W-1:0] absdiff(
    input logic [PER_W-1:0] a,
    input logic [PER_W-1:0] b
  );
    absdiff = (a > b) ? (a - b) : (b - a);
  endfunction

  // Saturating period counter step
  function automatic logic [PER_W-1:0] sat_inc(
    input logic [PER_W-1:0] v
  );
    sat_inc = (v == PER_MAX) ? v : v + 1'b1;
  endfunction

  logic [MULT_W-1:0]  mult_ff;
  logic [REFERENCE_DIVIDE_FIELD_W-1:0] reference_divide_field_ff;
  logic               lock_interrupt_enable_ff;
  logic               synsel_ff;
  logic               synon_ff;
  logic               auto_ff;
  logic               acq_ff;
  logic               dbg_freeze_ff;
  logic               dbg_written_ff;
  logic               lock_ff;
  logic               track_ff;
  logic               lockchg_ff;
  logic               sel_active_ff;
  logic               xtal_prev_ff;
  logic               syn_prev_ff;
  logic [REFERENCE_DIVIDE_FIELD_W-1:0] ref_cnt_ff;
  logic [MULT_W:0]    fb_cnt_ff;
  logic [PER_W-1:0]   ref_per_cnt_ff;
  logic [PER_W-1:0]   fb_per_cnt_ff;
  logic [PER_W-1:0]   ref_per_ff;
  logic [PER_W-1:0]   fb_per_ff;
  logic [2:0]         sw_cnt_ff;
  power_state_e       pw_state_ff;
  switch_state_e      sw_state_ff;

  logic               wr;
  logic               rd;
  logic               xtal_rise;
  logic               syn_rise;
  logic               ref_tick;
  logic               fb_tick;
  logic               synth_on;
  logic [PER_W-1:0]   per_err;
  logic               nxt_lock;
  logic               nxt_track;
  logic               sys_src;

  // Bus strobes are ignored while a stop write holds the bus
  assign wr = bus_req.wr && !bus_hold_ff;
  assign rd = bus_req.rd && !bus_hold_ff;

  // Edge detection on the sampled source clocks
  assign xtal_rise = crystal_clock && !xtal_prev_ff;
  assign syn_rise  = synthesised_clock && !syn_prev_ff;

  always_ff @(posedge clock) begin
    if (rst) begin
      xtal_prev_ff <= 1'b0;
      syn_prev_ff  <= 1'b0;
    end else begin
      xtal_prev_ff <= crystal_clock;
      syn_prev_ff  <= synthesised_clock;
    end
  end

  // Divider and interrupt enable registers
  always_ff @(posedge clock) begin
    if (rst) begin
      mult_ff   <= MULT_RST;
      reference_divide_field_ff  <= REFERENCE_DIVIDE_FIELD_RST;
      lock_interrupt_enable_ff <= 1'b0;
    end else if (wr) begin
      if (bus_req.addr == OFS_MULT) begin
        mult_ff <= bus_req.wdata[MULT_W-1:0];
      end else if (bus_req.addr == OFS_REFERENCE_DIVIDE_REGISTER) begin
        reference_divide_field_ff <= bus_req.wdata[REFERENCE_DIVIDE_FIELD_W-1:0];
      end else if (bus_req.addr == OFS_INT) begin
        lock_interrupt_enable_ff <= bus_req.wdata[BIT_LOCK_INTERRUPT_ENABLE];
      end
    end
  end

  // Synthesiser control and clock select registers
  always_ff @(posedge clock) begin
    if (rst) begin
      synsel_ff <= 1'b0;
      synon_ff  <= 1'b0;
      auto_ff   <= AUTO_RST;
      acq_ff    <= ACQ_RST;
    end else if (wr) begin
      if (bus_req.addr == OFS_SELECT) begin
        synsel_ff <= bus_req.wdata[BIT_SYNSEL];
      end else if (bus_req.addr == OFS_SYNCTL) begin
        if (!synsel_ff) begin
          synon_ff <= bus_req.wdata[BIT_SYNON];
        end
        auto_ff <= bus_req.wdata[BIT_AUTO];
        acq_ff  <= bus_req.wdata[BIT_ACQ];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      dbg_freeze_ff  <= 1'b0;
      dbg_written_ff <= 1'b0;
    end else if (wr && bus_req.addr == OFS_DBGFREEZE
                 && !dbg_written_ff) begin
      dbg_freeze_ff  <= bus_req.wdata[BIT_DBGFREEZE];
      dbg_written_ff <= 1'b1;
    end
  end

  // counter run gates in debug mode
  always_ff @(posedge clock) begin
    if (rst) begin
      watchdog_run_ff <= 1'b1;
      tick_run_ff     <= 1'b1;
    end else begin
      watchdog_run_ff <= !(dbg_freeze_ff && debug_mode);
      tick_run_ff     <= !(dbg_freeze_ff && debug_mode);
    end
  end

  // Power mode sequencer
  always_ff @(posedge clock) begin
    if (rst) begin
      pw_state_ff <= PW_RUN;
    end else begin
      case (pw_state_ff)
        PW_RUN: begin
          if (wr && bus_req.addr == OFS_STOPDOZE) begin
            if (bus_req.wdata[BIT_STOP]) begin
              pw_state_ff <= PW_STOP_WAIT;
            end else if (bus_req.wdata[BIT_DOZE]) begin
              pw_state_ff <= PW_DOZE;
            end
          end
        end
        PW_DOZE: begin
          if (wakeup) begin
            pw_state_ff <= PW_RUN;
          end
        end
        PW_STOP_WAIT: begin
          if (clocks_off_ready) begin
            pw_state_ff <= PW_STOPPED;
          end
        end
        PW_STOPPED: begin
          if (wakeup) begin
            pw_state_ff <= PW_RUN;
          end
        end
        default: begin
          pw_state_ff <= PW_RUN;
        end
      endcase
    end
  end

  // Mode outputs; bus held from stop write until wake-up
  always_ff @(posedge clock) begin
    if (rst) begin
      bus_hold_ff    <= 1'b0;
      doze_mode_ff   <= 1'b0;
      stop_clocks_ff <= 1'b0;
    end else begin
      bus_hold_ff    <= (pw_state_ff == PW_STOP_WAIT)
                        || (pw_state_ff == PW_STOPPED && !wakeup)
                        || (pw_state_ff == PW_RUN && wr
                            && bus_req.addr == OFS_STOPDOZE
                            && bus_req.wdata[BIT_STOP]);
      doze_mode_ff   <= (pw_state_ff == PW_DOZE) && !wakeup;
      stop_clocks_ff <= (pw_state_ff == PW_STOP_WAIT && clocks_off_ready)
                        || (pw_state_ff == PW_STOPPED && !wakeup);
    end
  end

  // synthesiser stays on while it drives the system
  assign synth_on = synon_ff || synsel_ff || sel_active_ff
                    || self_clock_mode;

  always_ff @(posedge clock) begin
    if (rst) begin
      synth_enable_ff <= 1'b0;
    end else begin
      synth_enable_ff <= synth_on;
    end
  end

  // reference divider, one tick every divide field plus one edges
  assign ref_tick = xtal_rise && (ref_cnt_ff == reference_divide_field_ff);

  always_ff @(posedge clock) begin
    if (rst) begin
      ref_cnt_ff   <= '0;
      ref_clock_ff <= 1'b0;
    end else if (xtal_rise) begin
      ref_cnt_ff   <= ref_tick ? '0 : ref_cnt_ff + 1'b1;
      ref_clock_ff <= ref_tick;
    end else begin
      ref_clock_ff <= 1'b0;
    end
  end

  // feedback divider, ratio 2 x (mult+1)
  // loop settles at 2 x crystal x (mult+1)/(div+1)
  assign fb_tick = syn_rise
                   && (fb_cnt_ff == {mult_ff, 1'b1});

  always_ff @(posedge clock) begin
    if (rst) begin
      fb_cnt_ff   <= '0;
      fb_clock_ff <= 1'b0;
    end else if (syn_rise) begin
      fb_cnt_ff   <= fb_tick ? '0 : fb_cnt_ff + 1'b1;
      fb_clock_ff <= fb_tick;
    end else begin
      fb_clock_ff <= 1'b0;
    end
  end

  // Period measurement of reference and feedback ticks
  always_ff @(posedge clock) begin
    if (rst) begin
      ref_per_cnt_ff <= '0;
      ref_per_ff     <= PER_MAX;
    end else if (ref_tick) begin
      ref_per_cnt_ff <= '0;
      ref_per_ff     <= ref_per_cnt_ff;
    end else begin
      ref_per_cnt_ff <= sat_inc(ref_per_cnt_ff);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      fb_per_cnt_ff <= '0;
      fb_per_ff     <= '0;
    end else if (fb_tick) begin
      fb_per_cnt_ff <= '0;
      fb_per_ff     <= fb_per_cnt_ff;
    end else begin
      fb_per_cnt_ff <= sat_inc(fb_per_cnt_ff);
    end
  end

  assign per_err = absdiff(ref_per_ff, fb_per_ff);

  // Lock and track with hysteresis
  always_comb begin
    nxt_lock  = lock_ff;
    nxt_track = track_ff;
    if (!synth_on) begin
      nxt_lock  = 1'b0;
      nxt_track = 1'b0;
    end else begin
      if (per_err <= TOL_LOCK) begin
        nxt_lock = 1'b1;
      end else if (per_err > TOL_UNLOCK) begin
        nxt_lock = 1'b0;
      end
      // automatic track decision by lock detector
      if (auto_ff) begin
        if (per_err <= TOL_TRACK) begin
          nxt_track = 1'b1;
        end else if (per_err > TOL_UNTRACK) begin
          nxt_track = 1'b0;
        end
      end else begin
        nxt_track = !acq_ff;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      lock_ff  <= 1'b0;
      track_ff <= 1'b0;
    end else begin
      lock_ff  <= nxt_lock;
      track_ff <= nxt_track;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      filter_acq_ff <= 1'b1;
    end else begin
      filter_acq_ff <= auto_ff ? !nxt_track : acq_ff;
    end
  end

  // lock change flag, set wins over write-one clear
  always_ff @(posedge clock) begin
    if (rst) begin
      lockchg_ff <= 1'b0;
    end else if (nxt_lock != lock_ff) begin
      lockchg_ff <= 1'b1;
    end else if (wr && bus_req.addr == OFS_FLAG
                 && bus_req.wdata[BIT_LOCKCHG]) begin
      lockchg_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      lock_irq_ff <= 1'b0;
    end else begin
      lock_irq_ff <= lock_interrupt_enable_ff && (lockchg_ff || (nxt_lock != lock_ff));
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      sw_state_ff     <= SW_IDLE;
      sw_cnt_ff       <= '0;
      sel_active_ff   <= 1'b0;
      clock_freeze_ff <= 1'b0;
    end else begin
      case (sw_state_ff)
        SW_IDLE: begin
          if (synsel_ff != sel_active_ff) begin
            sw_state_ff     <= SW_XTAL;
            sw_cnt_ff       <= '0;
            clock_freeze_ff <= 1'b1;
          end
        end
        SW_XTAL: begin
          if (xtal_rise) begin
            if (sw_cnt_ff == 3'(XTAL_EDGES - 1)) begin
              sw_state_ff <= SW_SYN;
              sw_cnt_ff   <= '0;
            end else begin
              sw_cnt_ff <= sw_cnt_ff + 1'b1;
            end
          end
        end
        SW_SYN: begin
          if (syn_rise) begin
            if (sw_cnt_ff == 3'(SYN_EDGES - 1)) begin
              sw_state_ff     <= SW_IDLE;
              sel_active_ff   <= synsel_ff;
              clock_freeze_ff <= 1'b0;
            end else begin
              sw_cnt_ff <= sw_cnt_ff + 1'b1;
            end
          end
        end
        default: begin
          sw_state_ff <= SW_IDLE;
        end
      endcase
    end
  end

  assign sys_src = sel_active_ff ? synthesised_clock : crystal_clock;

  // peripheral clock toggles on each system clock rise
  always_ff @(posedge clock) begin
    if (rst) begin
      system_clock_ff         <= 1'b0;
      peripheral_bus_clock_ff <= 1'b0;
    end else if (!clock_freeze_ff && !stop_clocks_ff) begin
      system_clock_ff <= sys_src;
      if (sys_src && !system_clock_ff) begin
        peripheral_bus_clock_ff <= !peripheral_bus_clock_ff;
      end
    end
  end

  // self-clock mode swaps the crystal-derived clock
  always_ff @(posedge clock) begin
    if (rst) begin
      osc_derived_clock_ff <= 1'b0;
    end else begin
      osc_derived_clock_ff <= self_clock_mode ? synthesised_clock
                                              : crystal_clock;
    end
  end

  // Read data, one cycle after the read strobe
  // reserved bits read zero
  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_ff <= '0;
    end else if (rd) begin
      rdata_ff <= '0;
      if (bus_req.addr == OFS_MULT) begin
        rdata_ff[MULT_W-1:0] <= mult_ff;
      end else if (bus_req.addr == OFS_REFERENCE_DIVIDE_REGISTER) begin
        rdata_ff[REFERENCE_DIVIDE_FIELD_W-1:0] <= reference_divide_field_ff;
      end else if (bus_req.addr == OFS_FLAG) begin
        rdata_ff[BIT_LOCKCHG] <= lockchg_ff;
        rdata_ff[BIT_LOCK]    <= lock_ff;
        rdata_ff[BIT_TRACK]   <= track_ff;
      end else if (bus_req.addr == OFS_INT) begin
        rdata_ff[BIT_LOCK_INTERRUPT_ENABLE] <= lock_interrupt_enable_ff;
      end else if (bus_req.addr == OFS_SELECT) begin
        rdata_ff[BIT_SYNSEL] <= synsel_ff;
      end else if (bus_req.addr == OFS_SYNCTL) begin
        rdata_ff[BIT_SYNON] <= synon_ff;
        rdata_ff[BIT_AUTO]  <= auto_ff;
        rdata_ff[BIT_ACQ]   <= acq_ff;
      end else if (bus_req.addr == OFS_STOPDOZE) begin
        rdata_ff[BIT_DOZE] <= doze_mode_ff;
      end else begin
        rdata_ff[BIT_DBGFREEZE] <= dbg_freeze_ff;
      end
    end
  end

endmodule
